// >>> rtl/fsm_pkg.sv
package fsm_pkg;
    // clock and delay-unit timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
    // register byte offsets
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OCF = 8'h04;
    localparam logic [7:0] A_OCW = 8'h08;
    localparam logic [7:0] A_UCF = 8'h0c;
    localparam logic [7:0] A_COFS = 8'h10;
    localparam logic [7:0] A_CGAIN = 8'h14;
    localparam logic [7:0] A_OCRSP = 8'h18;
    localparam logic [7:0] A_UCRSP = 8'h1c;
    localparam logic [7:0] A_SWORD = 8'h20;
    localparam logic [7:0] A_SDET = 8'h24;
    localparam logic [7:0] A_STATE = 8'h40;
    localparam int unsigned NDET = 7;
    // control fields
    localparam int unsigned CTRL_CLR = 0;
    localparam int unsigned CTRL_ON = 1;
    // reset values
    localparam logic RST_ON = 1'b1;
    localparam logic [15:0] RST_OCF = 16'hc000;
    localparam logic [15:0] RST_OCW = 16'ha000;
    localparam logic [15:0] RST_UCF = 16'h0000;
    localparam logic [15:0] RST_COFS = 16'h0000;
    localparam logic [15:0] RST_CGAIN = 16'h0100;
    localparam logic [7:0] RST_OCRSP = 8'h80;
    localparam logic [7:0] RST_UCRSP = 8'h00;
    localparam int unsigned GAIN_FRAC = 8;
    // status bit positions
    localparam int unsigned SI_OCF = 7;
    localparam int unsigned SI_OCW = 5;
    localparam int unsigned SI_UCF = 4;
    localparam int unsigned SB_OFF = 6;
    localparam int unsigned SB_OCF = 4;
    localparam int unsigned SB_OTHER = 0;
    localparam int unsigned SW_IOUT = 14;
    // response byte codes
    localparam logic [1:0] RSP_RUN = 2'h0;
    localparam logic [1:0] RSP_DLY = 2'h1;
    localparam logic [1:0] RSP_SHUT = 2'h2;
    localparam logic [1:0] RSP_INH = 2'h3;
    localparam logic [2:0] RETRY_INF = 3'h7;
    typedef enum logic [2:0] {
        FSM_RUN, FSM_DLY, FSM_WAIT, FSM_LATCH, FSM_INH
    } fsm_state_t;
endpackage

// >>> rtl/fsm_iref.sv
`timescale 1ns/1ps
module fsm_iref import fsm_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // threshold and calibration
    input wire logic [15:0] limit_i,
    input wire logic [15:0] ofs_i,
    input wire logic [15:0] gain_i,
    // measurement and results
    input wire logic [15:0] meas_i,
    output logic above_o,
    output logic below_o
);
    logic signed [16:0] diff;
    logic [31:0] prod;
    logic [15:0] ref_d;
    logic [15:0] ref_q;
    // ref_q is zero until its first load, so no compare is trusted before then
    logic ref_ok_q;
    assign diff = $signed({1'b0, limit_i}) - $signed({1'b0, ofs_i}); // R2
    assign prod = diff[15:0] * gain_i; // R2
    // negative difference clamps to zero, overflow saturates
    assign ref_d = diff[16] ? 16'h0000 :
        (|prod[31:16+GAIN_FRAC]) ? 16'hffff : prod[15+GAIN_FRAC:GAIN_FRAC];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ref_q <= 16'h0000;
            ref_ok_q <= 1'b0;
            above_o <= 1'b0;
            below_o <= 1'b0;
        end else begin
            ref_q <= ref_d;
            ref_ok_q <= 1'b1;
            above_o <= ref_ok_q && (meas_i > ref_q); // R1
            below_o <= ref_ok_q && (meas_i < ref_q); // R1
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_neg_ref;
        (limit_i < ofs_i) |=> (ref_q == 16'h0000);
    endproperty
    a_neg_ref: assert property (p_neg_ref) else $error("reference not clamped"); // R2
    property p_cmp;
        ref_ok_q && (meas_i > ref_q) |=> above_o && !below_o;
    endproperty
    a_cmp: assert property (p_cmp) else $error("detector compare wrong"); // R1
endmodule // fsm_iref

// >>> rtl/fsm_resp.sv
`timescale 1ns/1ps
module fsm_resp import fsm_pkg::*; (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // control
    input wire logic [7:0] resp_i,
    input wire logic fault_i,
    input wire logic tick_i,
    input wire logic restart_i,
    // result
    output logic off_o
);
    fsm_state_t st_q, st_d;
    logic [2:0] cnt_q, cnt_d;
    logic [2:0] used_q, used_d;
    logic [1:0] code;
    logic [2:0] retry;
    logic [2:0] dly;
    logic can_retry;
    logic shut_st;
    assign code = resp_i[7:6]; // R18
    assign retry = resp_i[5:3]; // R18
    assign dly = resp_i[2:0]; // R18
    assign can_retry = (retry == RETRY_INF) || (used_q < retry); // R20
    assign shut_st = can_retry; // 1: wait then retry, 0: latch off
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        used_d = used_q;
        unique case (st_q)
            FSM_RUN: if (fault_i) begin // R19
                unique case (code)
                    RSP_RUN: st_d = FSM_RUN; // R23
                    RSP_DLY: begin // R23 R21
                        st_d = FSM_DLY;
                        cnt_d = dly;
                    end
                    RSP_SHUT: begin // R22 R7
                        st_d = shut_st ? FSM_WAIT : FSM_LATCH;
                        cnt_d = dly; // R21
                    end
                    RSP_INH: st_d = FSM_INH; // R22
                endcase
            end
            FSM_DLY: if (!fault_i) begin
                st_d = FSM_RUN;
            end else if (cnt_q == 3'h0) begin // R23 R7
                st_d = shut_st ? FSM_WAIT : FSM_LATCH;
                cnt_d = dly;
            end else if (tick_i) begin
                cnt_d = cnt_q - 3'h1;
            end
            FSM_WAIT: if (cnt_q == 3'h0) begin // R20
                st_d = FSM_RUN;
                if (retry != RETRY_INF) begin
                    used_d = used_q + 3'h1;
                end
            end else if (tick_i) begin
                cnt_d = cnt_q - 3'h1;
            end
            FSM_LATCH: st_d = FSM_LATCH; // R7
            FSM_INH: if (!fault_i) begin // R22
                st_d = FSM_RUN;
            end
        endcase
        // an off/on cycle of the output restarts with a full retry budget
        if (restart_i) begin
            st_d = FSM_RUN;
            used_d = 3'h0;
        end
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q <= FSM_RUN;
            cnt_q <= 3'h0;
            used_q <= 3'h0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            used_q <= used_d;
        end
    end
    assign off_o = (st_q == FSM_WAIT) || (st_q == FSM_LATCH) || (st_q == FSM_INH); // R6
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_latch_holds;
        (st_q == FSM_LATCH) && !restart_i |=> off_o;
    endproperty
    a_latch_holds: assert property (p_latch_holds) else $error("latch-off released"); // R7
    property p_inhibit;
        (st_q == FSM_RUN) && fault_i && (code == RSP_INH) && !restart_i
            |=> off_o ##1 (!fault_i || off_o);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit not applied"); // R22
    property p_no_stop;
        (st_q == FSM_RUN) && (code == RSP_RUN) |=> !off_o;
    endproperty
    a_no_stop: assert property (p_no_stop) else $error("run code stopped output"); // R23
endmodule // fsm_resp

// >>> rtl/fsm_top.sv
// Function
// R1: detect output overcurrent fault, warning and undercurrent fault against derived references
// R2: reference equals programmed threshold minus calibration offset, times calibration gain
// R3: each exceeded threshold latches its own dedicated status bit
// R4: a warning sets its status bit and output keeps running
// R5: set bits are left for polling and also raise the alert output
// R6: a serious fault may disable the output and stop energy transfer
// R7: reaction is programmable: latch-off, shutdown with retry, or delayed shutdown
// R8: a fault sets its status bit besides performing the programmed reaction
// R9: latched bits stay set after the condition goes until a clearing event
// R10: the clear-faults command clears every latched warning and fault bit
// R11: device reset clears every latched status bit
// R12: commanding output off then on, by pin or command, clears all bits
// R13: a still-present condition sets its bit again right after clearing
// R14: status byte summarises critical bits; status word adds summaries in high byte
// R15: seven detailed status registers, chosen by host from summary bits
// R16: bits set individually and accumulate without disturbing others
// R17: a clearing event clears all bits of all registers at once
// R18: each fault has a one-byte response holding response, retry and delay
// R19: response chooses run on, shut down, or inhibit while fault persists
// R20: retry setting chooses whether restart is attempted after shutdown
// R21: delay means run-on time or time between retries depending on choices
// R22: code 10 shuts down and follows retry; 11 inhibits until fault clears
// R23: code 00 runs on; 01 runs for delay then applies retry setting
// R24: a set and a clear in one cycle leave the bit set
`timescale 1ns/1ps
module fsm_top import fsm_pkg::*; #(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // current measurement
    input wire logic [15:0] meas_i,
    // set conditions of the other six detailed registers
    input wire logic [47:0] det_set_i,
    // output control pin, asynchronous
    input wire logic ctrl_pin_i,
    // output enable and host alert
    output logic out_en_o,
    output logic alert_o
);
    // configuration registers
    logic on_q;
    logic [15:0] ocf_q;
    logic [15:0] ocw_q;
    logic [15:0] ucf_q;
    logic [15:0] ofs_q;
    logic [15:0] gain_q;
    logic [7:0] ocr_q;
    logic [7:0] ucr_q;
    // status
    logic [7:0] stat_q [NDET];
    logic [7:0] set_w [NDET];
    logic [15:0] sword;
    logic any_other;
    logic any_stat;
    // pin synchroniser and on/off tracking
    logic pin_m_q;
    logic pin_s_q;
    logic cmd_on;
    logic cmd_on_q;
    logic restart;
    // detector and response results
    logic oc_f;
    logic oc_w;
    logic uc_f;
    logic uc_lo;
    logic ocw_hi;
    logic oc_off;
    logic uc_off;
    // delay-unit divider
    logic [31:0] div_q;
    logic tick;
    // bus decode
    logic wr;
    logic rd_setup;
    logic clr_cmd;
    logic clr;
    logic det_hit;
    logic [2:0] det_idx;
    logic mapped;
    logic [31:0] rd_mux;
    logic [31:0] prdata_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    // apb: zero wait states, read data captured in setup
    assign wr = psel_i && penable_i && pwrite_i;
    assign rd_setup = psel_i && !penable_i && !pwrite_i;
    assign det_hit = (paddr_i >= A_SDET) && (paddr_i < A_STATE) && (paddr_i[1:0] == 2'h0);
    assign det_idx = 3'((paddr_i - A_SDET) >> 2);
    assign mapped = hit(paddr_i, A_CTRL) || hit(paddr_i, A_OCF) ||
        hit(paddr_i, A_OCW) || hit(paddr_i, A_UCF) ||
        hit(paddr_i, A_COFS) || hit(paddr_i, A_CGAIN) ||
        hit(paddr_i, A_OCRSP) || hit(paddr_i, A_UCRSP) ||
        hit(paddr_i, A_SWORD) || hit(paddr_i, A_STATE) || det_hit;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign prdata_o = prdata_q;

    // clearing events
    assign clr_cmd = wr && hit(paddr_i, A_CTRL) && pwdata_i[CTRL_CLR]; // R10
    assign cmd_on = on_q && pin_s_q; // R12
    assign restart = cmd_on && !cmd_on_q; // R12
    assign clr = clr_cmd || restart; // R17

    // current detectors
    fsm_iref u_ocf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .limit_i(ocf_q),
        .ofs_i(ofs_q),
        .gain_i(gain_q),
        .meas_i(meas_i),
        .above_o(oc_f),
        .below_o()
    );
    fsm_iref u_ocw (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .limit_i(ocw_q),
        .ofs_i(ofs_q),
        .gain_i(gain_q),
        .meas_i(meas_i),
        .above_o(ocw_hi),
        .below_o()
    );
    fsm_iref u_ucf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .limit_i(ucf_q),
        .ofs_i(ofs_q),
        .gain_i(gain_q),
        .meas_i(meas_i),
        .above_o(),
        .below_o(uc_lo)
    );
    assign oc_w = ocw_hi; // R4
    assign uc_f = uc_lo;

    // fault reactions; the warning has none
    fsm_resp u_ocrsp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .resp_i(ocr_q),
        .fault_i(oc_f),
        .tick_i(tick),
        .restart_i(restart),
        .off_o(oc_off)
    );
    fsm_resp u_ucrsp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .resp_i(ucr_q),
        .fault_i(uc_f),
        .tick_i(tick),
        .restart_i(restart),
        .off_o(uc_off)
    );
    assign out_en_o = cmd_on && !oc_off && !uc_off; // R6

    // delay unit tick
    assign tick = (div_q == 32'(TICK_CYCLES - 1));
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= 32'h0;
        end else begin
            div_q <= tick ? 32'h0 : div_q + 32'h1;
        end
    end

    // set sources: register 0 holds the output-current bits
    always_comb begin
        set_w[0] = 8'h00;
        set_w[0][SI_OCF] = oc_f; // R3 R8
        set_w[0][SI_OCW] = oc_w; // R3 R4
        set_w[0][SI_UCF] = uc_f; // R3 R8
        for (int k = 1; k < NDET; k++) begin
            set_w[k] = det_set_i[8*(k-1) +: 8]; // R15
        end
    end

    // sticky status; set beats a same-cycle clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int k = 0; k < NDET; k++) begin
                stat_q[k] <= 8'h00; // R11
            end
        end else begin
            for (int k = 0; k < NDET; k++) begin
                stat_q[k] <= (stat_q[k] & ~{8{clr}}) | set_w[k]; // R9 R16 R17 R24 R13
            end
        end
    end

    // summary byte and word
    always_comb begin
        any_other = 1'b0;
        for (int k = 1; k < NDET; k++) begin
            any_other = any_other | (|stat_q[k]);
        end
        sword = 16'h0000;
        sword[SB_OFF] = !out_en_o; // R14
        sword[SB_OCF] = stat_q[0][SI_OCF]; // R14
        sword[SB_OTHER] = any_other; // R14
        for (int k = 1; k < NDET; k++) begin
            sword[8+k-1] = |stat_q[k]; // R14 R15
        end
        sword[SW_IOUT] = |stat_q[0]; // R14
    end
    assign any_stat = |stat_q[0] || any_other;

    // read mux
    always_comb begin
        rd_mux = 32'h0;
        if (det_hit) begin
            rd_mux = {24'h0, stat_q[det_idx]}; // R15
        end else begin
            unique case (1'b1)
                hit(paddr_i, A_CTRL): rd_mux[CTRL_ON] = on_q;
                hit(paddr_i, A_OCF): rd_mux = {16'h0, ocf_q};
                hit(paddr_i, A_OCW): rd_mux = {16'h0, ocw_q};
                hit(paddr_i, A_UCF): rd_mux = {16'h0, ucf_q};
                hit(paddr_i, A_COFS): rd_mux = {16'h0, ofs_q};
                hit(paddr_i, A_CGAIN): rd_mux = {16'h0, gain_q};
                hit(paddr_i, A_OCRSP): rd_mux = {24'h0, ocr_q};
                hit(paddr_i, A_UCRSP): rd_mux = {24'h0, ucr_q};
                hit(paddr_i, A_SWORD): rd_mux = {16'h0, sword}; // R14
                hit(paddr_i, A_STATE): rd_mux = {28'h0, uc_off, oc_off, cmd_on, out_en_o};
                default: rd_mux = 32'h0;
            endcase
        end
    end

    // register writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            on_q <= RST_ON;
            ocf_q <= RST_OCF;
            ocw_q <= RST_OCW;
            ucf_q <= RST_UCF;
            ofs_q <= RST_COFS;
            gain_q <= RST_CGAIN;
            ocr_q <= RST_OCRSP;
            ucr_q <= RST_UCRSP;
        end else if (wr) begin
            if (hit(paddr_i, A_CTRL)) on_q <= pwdata_i[CTRL_ON];
            if (hit(paddr_i, A_OCF)) ocf_q <= pwdata_i[15:0];
            if (hit(paddr_i, A_OCW)) ocw_q <= pwdata_i[15:0];
            if (hit(paddr_i, A_UCF)) ucf_q <= pwdata_i[15:0];
            if (hit(paddr_i, A_COFS)) ofs_q <= pwdata_i[15:0];
            if (hit(paddr_i, A_CGAIN)) gain_q <= pwdata_i[15:0];
            if (hit(paddr_i, A_OCRSP)) ocr_q <= pwdata_i[7:0]; // R18
            if (hit(paddr_i, A_UCRSP)) ucr_q <= pwdata_i[7:0]; // R18
        end
    end

    // read data, pin sync, on tracking, alert
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_q <= 32'h0;
            pin_m_q <= 1'b0;
            pin_s_q <= 1'b0;
            cmd_on_q <= 1'b0;
            alert_o <= 1'b0;
        end else begin
            if (rd_setup) begin
                prdata_q <= rd_mux;
            end
            pin_m_q <= ctrl_pin_i;
            pin_s_q <= pin_m_q;
            cmd_on_q <= cmd_on;
            alert_o <= any_stat; // R5
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_sticky;
        stat_q[0][SI_OCF] && !clr |=> stat_q[0][SI_OCF];
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit lost"); // R9
    property p_clear_all;
        clr && !oc_f && !oc_w && !uc_f && (det_set_i == 48'h0)
            |=> !(|stat_q[0]) && !any_other;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("clear incomplete"); // R17
    property p_set_wins;
        clr && oc_w |=> stat_q[0][SI_OCW];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // R24
    sequence s_off_on;
        !cmd_on ##1 cmd_on;
    endsequence
    property p_restart_clears;
        s_off_on ##0 !oc_f && !uc_f |=> !stat_q[0][SI_OCF] && !stat_q[0][SI_UCF];
    endproperty
    a_restart_clears: assert property (p_restart_clears) else $error("off/on left bits"); // R12
    property p_alert;
        any_stat |=> alert_o;
    endproperty
    a_alert: assert property (p_alert) else $error("alert missing"); // R5
    property p_word;
        stat_q[0][SI_OCF] |-> sword[SB_OCF] && sword[SW_IOUT];
    endproperty
    a_word: assert property (p_word) else $error("summary bits wrong"); // R14
    property p_fault_off;
        oc_off || uc_off |-> !out_en_o;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("output on during fault"); // R6
    // detailed register 1: each new bit lands and earlier bits stay
    property p_det_set;
        (det_set_i[7:0] != 8'h00)
            |=> ((stat_q[1] & $past(det_set_i[7:0])) == $past(det_set_i[7:0]));
    endproperty
    a_det_set: assert property (p_det_set) else $error("detail bit not set"); // R3
    property p_accum;
        !clr |=> ((stat_q[1] & $past(stat_q[1])) == $past(stat_q[1]));
    endproperty
    a_accum: assert property (p_accum) else $error("detail bits not kept"); // R16
    property p_cmd_clear;
        clr_cmd && !oc_w |=> !stat_q[0][SI_OCW];
    endproperty
    a_cmd_clear: assert property (p_cmd_clear) else $error("clear command ignored"); // R10
    property p_summary;
        |stat_q[1] |-> sword[SB_OTHER] && sword[8];
    endproperty
    a_summary: assert property (p_summary) else $error("detail summary missing"); // R14
endmodule // fsm_top

// >>> sim/fsm_host_model.sv
`timescale 1ns/1ps
module fsm_host_model import fsm_pkg::*; (
    // clock
    input wire logic clk_i,
    // apb master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0000_0000;
    end
    // no wait-state count assumed: only the bench watchdog ends a stuck wait
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk_i);
        psel_o <= 1'b1;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released lines show a changed pattern so stale values are never trusted
        pwrite_o <= ~wr;
        paddr_o <= ~a;
        pwdata_o <= ~d;
    endtask
    task automatic clear_faults(input logic on);
        logic [31:0] r;
        logic e;
        xfer(1'b1, A_CTRL, {30'h0, on, 1'b1}, r, e);
    endtask
    task automatic set_resp(input logic [7:0] a, input logic [7:0] b);
        logic [31:0] r;
        logic e;
        xfer(1'b1, a, {24'h0, b}, r, e);
    endtask
    // summary first, detail only when its summary bit says so
    task automatic poll(output logic [31:0] w, output logic [31:0] d);
        logic e;
        xfer(1'b0, A_SWORD, 32'h0, w, e);
        d = 32'h0;
        if (w[SW_IOUT] === 1'b1) xfer(1'b0, A_SDET, 32'h0, d, e);
    endtask
endmodule // fsm_host_model

// >>> sim/test_fault_status_manager.sv
`timescale 1ns/1ps
module test_fault_status_manager import fsm_pkg::*; ;
    logic clk, rst, psel, penable, pwrite, pin, pready, pslverr, out_en, alert, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [15:0] meas;
    logic [47:0] det;
    int bad_count = 0;
    int compares = 0;
    logic [7:0] ra [9] = '{A_CTRL, A_OCF, A_OCW, A_UCF, A_COFS, A_CGAIN, A_OCRSP, A_UCRSP, A_SWORD};
    logic [31:0] rv [9] = '{32'h2, 32'hc000, 32'ha000, 32'h0, 32'h0, 32'h100, 32'h80, 32'h0, 32'h0};
    fsm_top #(.TICK_CYCLES(4)) i_dut (.clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .meas_i(meas),
        .det_set_i(det), .ctrl_pin_i(pin), .out_en_o(out_en), .alert_o(alert));
    fsm_host_model u_host (.clk_i(clk), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic test_done();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_bit(input string nm, input logic exp, input logic got);
        chk(nm, {31'h0, exp}, {31'h0, got});
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        u_host.xfer(1'b0, a, 32'h0, rd, err);
        chk($sformatf("reg %h", a), exp, rd);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, rd, err);
    endtask
    // detection path is three edges deep, one spare
    task automatic sm(input logic [15:0] v);
        @(posedge clk);
        meas <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulse(input logic [47:0] v);
        @(posedge clk);
        det <= v;
        @(posedge clk);
        det <= 48'h0;
        repeat (3) @(posedge clk);
    endtask
    task automatic wait_en(input logic v, input int n);
        for (int i = 0; i < n && out_en !== v; i++) @(posedge clk);
        chk_bit("out_en", v, out_en);
    endtask
    task automatic restart();
        wr(A_CTRL, 32'h0);
        wr(A_CTRL, 32'h2);
        wait_en(1'b1, 10);
    endtask
    initial begin
        rst = 1'b1;
        meas = 16'h0000;
        det = 48'h0;
        pin = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (ra[i]) rdc(ra[i], rv[i]);
        rdc(A_STATE, 32'h3);
        chk_bit("pslverr", 1'b0, err);
        chk_bit("pready", 1'b1, pready);
        for (int i = 0; i < NDET; i++) rdc(A_SDET + 8'(4 * i), 32'h0);
        u_host.xfer(1'b1, 8'h44, 32'hffff_ffff, rd, err);
        chk_bit("pslverr", 1'b1, err);
        rdc(8'h44, 32'h0);
        chk_bit("pslverr", 1'b1, err);
        wr(A_SWORD, 32'hffff);
        rdc(A_SWORD, 32'h0);
        // warn ref (0x3000-0x1000)*2=0x4000, fault ref (0x5000-0x1000)*2=0x8000
        wr(A_COFS, 32'h1000);
        wr(A_CGAIN, 32'h200);
        wr(A_OCW, 32'h3000);
        wr(A_OCF, 32'h5000);
        rdc(A_OCW, 32'h3000);
        u_host.set_resp(A_OCRSP, 8'h00);
        sm(16'h4000);
        rdc(A_SDET, 32'h0);
        sm(16'h4001);
        u_host.poll(w, rd);
        chk("word", 32'h4000, w);
        chk("detail", 32'h20, rd);
        chk_bit("out_en", 1'b1, out_en);
        chk_bit("alert", 1'b1, alert);
        sm(16'h0000);
        pulse(48'h1);
        pulse(48'h8);
        pulse(48'h1 << 40);
        rdc(A_SDET, 32'h20);
        rdc(A_SDET + 8'h04, 32'h09);
        rdc(A_SWORD, 32'h6101);
        u_host.clear_faults(1'b1);
        for (int i = 0; i < NDET; i++) rdc(A_SDET + 8'(4 * i), 32'h0);
        rdc(A_SWORD, 32'h0);
        chk_bit("alert", 1'b0, alert);
        sm(16'h4001);
        u_host.clear_faults(1'b1);
        rdc(A_SDET, 32'h20);
        sm(16'h0000);
        restart();
        rdc(A_SDET, 32'h0);
        pulse(48'h2);
        @(posedge clk);
        pin <= 1'b0;
        wait_en(1'b0, 4);
        @(posedge clk);
        pin <= 1'b1;
        wait_en(1'b1, 6);
        rdc(A_SDET + 8'h04, 32'h0);
        sm(16'h9000);
        repeat (40) @(posedge clk);
        chk_bit("out_en", 1'b1, out_en);
        rdc(A_SDET, 32'ha0);
        rdc(A_SWORD, 32'h4010);
        sm(16'h0000);
        u_host.set_resp(A_OCRSP, 8'h42);
        sm(16'h9000);
        chk_bit("out_en", 1'b1, out_en);
        wait_en(1'b0, 30);
        sm(16'h0000);
        repeat (30) @(posedge clk);
        chk_bit("out_en", 1'b0, out_en);
        restart();
        u_host.set_resp(A_OCRSP, 8'h80);
        sm(16'h9000);
        wait_en(1'b0, 8);
        rdc(A_STATE, 32'h6);
        sm(16'h0000);
        u_host.clear_faults(1'b1);
        repeat (20) @(posedge clk);
        chk_bit("out_en", 1'b0, out_en);
        restart();
        u_host.set_resp(A_OCRSP, 8'hb9);
        sm(16'h9000);
        wait_en(1'b0, 8);
        sm(16'h0000);
        wait_en(1'b1, 40);
        u_host.set_resp(A_OCRSP, 8'hc0);
        sm(16'h9000);
        wait_en(1'b0, 8);
        repeat (20) @(posedge clk);
        chk_bit("out_en", 1'b0, out_en);
        sm(16'h0000);
        wait_en(1'b1, 12);
        // undercurrent ref (0x1800-0x1000)*2=0x1000
        wr(A_UCF, 32'h1800);
        u_host.clear_faults(1'b1);
        sm(16'h0800);
        rdc(A_SDET, 32'h10);
        chk_bit("out_en", 1'b1, out_en);
        u_host.set_resp(A_UCRSP, 8'hc0);
        wait_en(1'b0, 8);
        rdc(A_STATE, 32'ha);
        sm(16'h2000);
        wait_en(1'b1, 12);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc(A_SDET + 8'h04, 32'h0);
        rdc(A_UCF, 32'h0);
        test_done();
    end
    initial begin
        #60000;
        bad_count++;
        test_done();
    end
endmodule // test_fault_status_manager
